// *** include/cmp_skip_defines.svh ***
// Behaviour
// - Compare-and-skip-if-equal skips the next instruction when both registers match, moving the program counter on by 2 or 3 in 1, 2 or 3 cycles.
// - Register compares form destination minus source, keep no difference and change only the zero, negative, overflow, carry and half-carry flags.
// - Compare-with-carry subtracts the source and the present carry from the destination for the flags alone, in one cycle.
// - Compare-with-immediate subtracts a constant from the destination, sets the five arithmetic flags, keeps the register and takes one cycle.
// - Skip-if-register-bit-clear skips the next instruction when the chosen register bit is 0, moving the program counter on by 2 or 3.
// - Skip-if-register-bit-set skips the next instruction when the chosen register bit is 1, taking 1, 2 or 3 cycles.
// - Skip-if-io-bit-clear skips the next instruction when the chosen I/O register bit is 0, moving the program counter on by 2 or 3.
// - Skip-if-io-bit-set skips the next instruction when the chosen I/O register bit is 1, taking 1, 2 or 3 cycles.
// - Branch-on-status-flag-set loads the program counter with itself plus offset plus one when the chosen flag is 1, else goes on in sequence.
// - Bit-test skips and the flag branch leave every status flag as it was.
`ifndef CMP_SKIP_DEFINES_SVH
`define CMP_SKIP_DEFINES_SVH

`define DATA_WIDTH      8
`define PC_WIDTH        16
`define OFFSET_WIDTH    7
`define SEL_WIDTH       3

`define FLAG_C          0
`define FLAG_Z          1
`define FLAG_N          2
`define FLAG_V          3
`define FLAG_S          4
`define FLAG_H          5

`define PC_STEP_NORMAL  16'h0001
`define PC_STEP_SKIP1   16'h0002
`define PC_STEP_SKIP2   16'h0003
`define EXTRA_SKIP1     2'h1
`define EXTRA_SKIP2     2'h2
`define EXTRA_BRANCH    2'h1
`define EXTRA_NONE      2'h0

`define PC_RESET        16'h0000
`define FLAGS_RESET     8'h00

`endif

// *** include/cmp_skip_pkg.sv ***
`include "cmp_skip_defines.svh"
package cmp_skip_pkg;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_COMPARE_SKIP_IF_EQUAL,
		OP_COMPARE_REGISTERS,
		OP_COMPARE_WITH_CARRY,
		OP_COMPARE_WITH_IMMEDIATE,
		OP_SKIP_IF_REGISTER_BIT_CLEAR,
		OP_SKIP_IF_REGISTER_BIT_SET,
		OP_SKIP_IF_IO_BIT_CLEAR,
		OP_SKIP_IF_IO_BIT_SET,
		OP_BRANCH_ON_STATUS_FLAG_SET
	} op_type;

	typedef struct packed {
		op_type                       op;
		logic [`DATA_WIDTH-1:0]       dst;
		logic [`DATA_WIDTH-1:0]       src;
		logic [`DATA_WIDTH-1:0]       io_value;
		logic [`SEL_WIDTH-1:0]        bit_sel;
		logic [`SEL_WIDTH-1:0]        flag_sel;
		logic [`OFFSET_WIDTH-1:0]     offset;
		logic                         next_two_words;
		logic [`PC_WIDTH-1:0]         pc;
		logic [`DATA_WIDTH-1:0]       flags;
	} exec_req_type;

	typedef struct packed {
		logic [`PC_WIDTH-1:0]         pc_next;
		logic [`DATA_WIDTH-1:0]       flags;
		logic                         flags_we;
		logic                         skipped;
		logic                         branched;
	} exec_res_type;

	typedef enum logic {
		ST_IDLE,
		ST_STALL
	} seq_state_type;

endpackage

// *** rtl/compare_skip_branch_exec.sv ***
`timescale 1ns/1ps
`include "cmp_skip_defines.svh"
module compare_skip_branch_exec (
	input  wire logic                       core_clk,
	input  wire logic                       resetn,
	input  wire logic                       req_valid,
	input  wire cmp_skip_pkg::exec_req_type req,
	output logic                            req_ready,
	output logic                            res_valid,
	output cmp_skip_pkg::exec_res_type      res
);

	// Operand selection
	wire cmp_skip_pkg::op_type      op;
	wire logic [`DATA_WIDTH-1:0]    dst;
	wire logic [`DATA_WIDTH-1:0]    src;
	wire logic [`DATA_WIDTH-1:0]    flags_in;
	wire logic                      carry_in;
	wire logic [`DATA_WIDTH:0]      diff_wide;
	wire logic [`DATA_WIDTH-1:0]    diff;

	assign op       = req.op;
	assign dst      = req.dst;
	assign src      = req.src;
	assign flags_in = req.flags;
	assign carry_in = (op == cmp_skip_pkg::OP_COMPARE_WITH_CARRY) ?
		flags_in[`FLAG_C] : 1'b0;

	// Difference only feeds the flags, never a register
	assign diff_wide = {1'b0, dst} - {1'b0, src} -
		{{`DATA_WIDTH{1'b0}}, carry_in};
	assign diff = diff_wide[`DATA_WIDTH-1:0];

	// Subtract flag terms
	wire logic  d7;
	wire logic  s7;
	wire logic  r7;
	wire logic  d3;
	wire logic  s3;
	wire logic  r3;
	wire logic  half_borrow;
	wire logic  borrow;
	wire logic  overflow;
	wire logic  negative;
	wire logic  diff_zero;
	wire logic  zero_flag;

	assign d7 = dst[`DATA_WIDTH-1];
	assign s7 = src[`DATA_WIDTH-1];
	assign r7 = diff[`DATA_WIDTH-1];
	assign d3 = dst[3];
	assign s3 = src[3];
	assign r3 = diff[3];

	assign half_borrow = (~d3 & s3) | (s3 & r3) | (r3 & ~d3);
	assign borrow      = (~d7 & s7) | (s7 & r7) | (r7 & ~d7);
	assign overflow    = (d7 & ~s7 & ~r7) | (~d7 & s7 & r7);
	assign negative    = r7;
	assign diff_zero   = (diff == {`DATA_WIDTH{1'b0}});
	// Chained compares keep zero only while every byte matched
	assign zero_flag   = (op == cmp_skip_pkg::OP_COMPARE_WITH_CARRY) ?
		(diff_zero & flags_in[`FLAG_Z]) : diff_zero;

	// Only five flags move; sign and the top bits stay put
	wire logic [`DATA_WIDTH-1:0]    flags_cmp;
	assign flags_cmp = {
		flags_in[7:6],
		half_borrow,
		flags_in[`FLAG_S],
		overflow,
		negative,
		zero_flag,
		borrow
	};

	// Op class decode
	wire logic  is_compare;
	wire logic  is_equal_skip;
	wire logic  is_reg_clr;
	wire logic  is_reg_set;
	wire logic  is_io_clr;
	wire logic  is_io_set;
	wire logic  is_branch;

	assign is_compare =
		(op == cmp_skip_pkg::OP_COMPARE_REGISTERS) |
		(op == cmp_skip_pkg::OP_COMPARE_WITH_CARRY) |
		(op == cmp_skip_pkg::OP_COMPARE_WITH_IMMEDIATE);
	assign is_equal_skip = (op == cmp_skip_pkg::OP_COMPARE_SKIP_IF_EQUAL);
	assign is_reg_clr = (op == cmp_skip_pkg::OP_SKIP_IF_REGISTER_BIT_CLEAR);
	assign is_reg_set = (op == cmp_skip_pkg::OP_SKIP_IF_REGISTER_BIT_SET);
	assign is_io_clr  = (op == cmp_skip_pkg::OP_SKIP_IF_IO_BIT_CLEAR);
	assign is_io_set  = (op == cmp_skip_pkg::OP_SKIP_IF_IO_BIT_SET);
	assign is_branch  = (op == cmp_skip_pkg::OP_BRANCH_ON_STATUS_FLAG_SET);

	// Tested bits
	wire logic  reg_bit;
	wire logic  io_bit;
	wire logic  flag_bit;

	assign reg_bit  = src[req.bit_sel];
	assign io_bit   = req.io_value[req.bit_sel];
	assign flag_bit = flags_in[req.flag_sel];

	wire logic  skip_hit;
	assign skip_hit =
		(is_equal_skip & (dst == src)) |
		(is_reg_clr & ~reg_bit) |
		(is_reg_set & reg_bit) |
		(is_io_clr & ~io_bit) |
		(is_io_set & io_bit);

	wire logic  branch_hit;
	assign branch_hit = is_branch & flag_bit;

	// Program counter target
	wire logic [`PC_WIDTH-1:0]  offset_ext;
	wire logic [`PC_WIDTH-1:0]  skip_step;
	wire logic [`PC_WIDTH-1:0]  pc_step;
	wire logic [`PC_WIDTH-1:0]  pc_target;

	assign offset_ext = {
		{(`PC_WIDTH-`OFFSET_WIDTH){req.offset[`OFFSET_WIDTH-1]}},
		req.offset
	};
	assign skip_step = req.next_two_words ?
		`PC_STEP_SKIP2 : `PC_STEP_SKIP1;
	assign pc_step = skip_hit ? skip_step :
		branch_hit ? (offset_ext + `PC_STEP_NORMAL) :
		`PC_STEP_NORMAL;
	assign pc_target = req.pc + pc_step;

	// Extra cycles beyond the first
	wire logic [1:0]    extra;
	assign extra = skip_hit ?
		(req.next_two_words ? `EXTRA_SKIP2 : `EXTRA_SKIP1) :
		branch_hit ? `EXTRA_BRANCH : `EXTRA_NONE;

	// Skips and the branch hand the flags back untouched
	wire cmp_skip_pkg::exec_res_type    res_calc;
	assign res_calc.pc_next  = pc_target;
	assign res_calc.flags    = is_compare ? flags_cmp : flags_in;
	assign res_calc.flags_we = is_compare;
	assign res_calc.skipped  = skip_hit;
	assign res_calc.branched = branch_hit;

	// Sequencer
	cmp_skip_pkg::seq_state_type    state_reg;
	cmp_skip_pkg::seq_state_type    state_next;
	logic [1:0]                     count_reg;
	logic [1:0]                     count_next;
	logic                           done_next;
	logic                           ready_reg;
	logic                           done_reg;
	cmp_skip_pkg::exec_res_type     res_reg;

	wire logic  accept;
	wire logic  known_op;
	assign known_op = is_compare | is_equal_skip | is_reg_clr | is_reg_set |
		is_io_clr | is_io_set | is_branch;
	// Unknown ops are swallowed so a stray strobe cannot wedge the core
	assign accept = req_valid & ready_reg & known_op;

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		done_next  = 1'b0;
		case (state_reg)
			cmp_skip_pkg::ST_IDLE: begin
				if (accept) begin
					if (extra == `EXTRA_NONE) begin
						done_next = 1'b1;
					end else begin
						state_next = cmp_skip_pkg::ST_STALL;
						count_next = extra;
					end
				end
			end
			cmp_skip_pkg::ST_STALL: begin
				count_next = count_reg - 2'h1;
				if (count_reg == 2'h1) begin
					done_next  = 1'b1;
					state_next = cmp_skip_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = cmp_skip_pkg::ST_IDLE;
				count_next = 2'h0;
			end
		endcase
	end

	wire cmp_skip_pkg::exec_res_type    res_hold;
	assign res_hold = accept ? res_calc : res_reg;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= cmp_skip_pkg::ST_IDLE;
			count_reg <= 2'h0;
			done_reg  <= 1'b0;
			ready_reg <= 1'b1;
			res_reg   <= '{`PC_RESET, `FLAGS_RESET, 1'b0, 1'b0, 1'b0};
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			done_reg  <= done_next;
			ready_reg <= (state_next == cmp_skip_pkg::ST_IDLE);
			res_reg   <= res_hold;
		end
	end

	assign req_ready = ready_reg;
	assign res_valid = done_reg;
	assign res       = res_reg;

endmodule

// *** verif/compare_skip_branch_exec_assertions.sv ***
`timescale 1ns/1ps
module compare_skip_branch_exec_assertions (
	input wire logic                       core_clk,
	input wire logic                       resetn,
	input wire logic                       req_valid,
	input wire cmp_skip_pkg::exec_req_type req,
	input wire logic                       req_ready,
	input wire logic                       res_valid,
	input wire cmp_skip_pkg::exec_res_type res
);
	wire logic        take = req_valid && req_ready &&
		req.op != cmp_skip_pkg::OP_NONE;
	wire logic        cmp_op = req.op inside {
		cmp_skip_pkg::OP_COMPARE_REGISTERS,
		cmp_skip_pkg::OP_COMPARE_WITH_CARRY,
		cmp_skip_pkg::OP_COMPARE_WITH_IMMEDIATE};
	// Bit tests and the flag branch sit after the compares in the enum
	wire logic        quiet_op = req.op > cmp_skip_pkg::OP_COMPARE_WITH_IMMEDIATE;
	wire logic        bit_val = req.op inside {
		cmp_skip_pkg::OP_SKIP_IF_IO_BIT_CLEAR,
		cmp_skip_pkg::OP_SKIP_IF_IO_BIT_SET} ?
		req.io_value[req.bit_sel] : req.src[req.bit_sel];
	wire logic        test_op = req.op == cmp_skip_pkg::OP_COMPARE_SKIP_IF_EQUAL
		|| (quiet_op && req.op != cmp_skip_pkg::OP_BRANCH_ON_STATUS_FLAG_SET);
	wire logic        hit = req.op == cmp_skip_pkg::OP_COMPARE_SKIP_IF_EQUAL ?
		req.dst == req.src : (req.op[0] ? !bit_val : bit_val);
	wire logic [15:0] target = req.pc + {{9{req.offset[6]}}, req.offset} + 16'h0001;
	wire logic        br_set = req.op ==
		cmp_skip_pkg::OP_BRANCH_ON_STATUS_FLAG_SET && req.flags[req.flag_sel];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	cmp_one_cycle_a: assert property (take && cmp_op |=> res_valid && res.flags_we)
		else $error("compare answer late");
	cmp_pass_a: assert property (take && cmp_op |=> res.flags[7:6] ==
		$past(req.flags[7:6]) && res.flags[4] == $past(req.flags[4]))
		else $error("compare touched other flags");
	cmp_zero_a: assert property (take && req.op == cmp_skip_pkg::OP_COMPARE_REGISTERS
		|=> res.flags[1] == ($past(req.dst) == $past(req.src)))
		else $error("compare zero flag wrong");
	carry_borrow_a: assert property (take &&
		req.op == cmp_skip_pkg::OP_COMPARE_WITH_CARRY |=> res.flags[0] ==
		({1'b0, $past(req.dst)} < {1'b0, $past(req.src)} + $past(req.flags[0])))
		else $error("carry compare borrow wrong");
	flags_kept_a: assert property (take && quiet_op |=>
		!res.flags_we && res.flags == $past(req.flags))
		else $error("test changed flags");
	skip_short_a: assert property (take && test_op && hit && !req.next_two_words
		|=> !res_valid && res.pc_next == $past(req.pc) + 16'h0002 ##1 res_valid)
		else $error("one word skip wrong");
	skip_long_a: assert property (take && test_op && hit && req.next_two_words
		|=> !res_valid && res.pc_next == $past(req.pc) + 16'h0003 ##1 !res_valid
		##1 res_valid) else $error("two word skip wrong");
	no_skip_a: assert property (take && test_op && !hit
		|=> res_valid && res.pc_next == $past(req.pc) + 16'h0001)
		else $error("failed test wrong");
	branch_taken_a: assert property (take &&
		req.op == cmp_skip_pkg::OP_BRANCH_ON_STATUS_FLAG_SET &&
		req.flags[req.flag_sel] |=> !res_valid && res.pc_next == $past(target)
		##1 res_valid) else $error("branch target wrong");
	stall_ready_a: assert property (take && (test_op && hit || br_set)
		|=> !req_ready) else $error("ready high in stall");
	quick_ready_a: assert property (take && !(test_op && hit || br_set)
		|=> req_ready) else $error("ready low after one cycle op");
	ready_back_a: assert property (res_valid |-> req_ready)
		else $error("ready low with result");
endmodule

bind compare_skip_branch_exec compare_skip_branch_exec_assertions chk (
	.core_clk(core_clk), .resetn(resetn), .req_valid(req_valid), .req(req),
	.req_ready(req_ready), .res_valid(res_valid), .res(res));

// *** verif/compare_skip_branch_exec_tb.sv ***
`timescale 1ns/1ps
module compare_skip_branch_exec_tb;
	logic                       core_clk = 1'b0;
	logic                       resetn = 1'b0;
	logic                       req_valid = 1'b0;
	cmp_skip_pkg::exec_req_type req = '0;
	cmp_skip_pkg::exec_req_type nxt;
	logic                       prev_ready = 1'b1;
	logic                       req_ready;
	logic                       res_valid;
	cmp_skip_pkg::exec_res_type res;
	cmp_skip_pkg::exec_res_type q[$];
	logic [95:0]                rnd;
	integer                     seed = 17875;
	integer                     fail_count = 0;
	integer                     checks = 0;

	always #5 core_clk = ~core_clk;

	compare_skip_branch_exec dut (.core_clk(core_clk), .resetn(resetn),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.res_valid(res_valid), .res(res));

	function automatic cmp_skip_pkg::exec_res_type model(
		input cmp_skip_pkg::exec_req_type r);
		cmp_skip_pkg::exec_res_type e;
		logic [7:0]                 x;
		logic                       c;
		logic                       io;
		logic signed [9:0]          sv;
		io = r.op inside {cmp_skip_pkg::OP_SKIP_IF_IO_BIT_CLEAR,
			cmp_skip_pkg::OP_SKIP_IF_IO_BIT_SET};
		c = r.op == cmp_skip_pkg::OP_COMPARE_WITH_CARRY && r.flags[0];
		x = r.dst - r.src - {7'h00, c};
		e = '0;
		e.flags = r.flags;
		e.pc_next = r.pc + 16'h0001;
		if (r.op inside {[cmp_skip_pkg::OP_COMPARE_REGISTERS :
			cmp_skip_pkg::OP_COMPARE_WITH_IMMEDIATE]}) begin
			e.flags_we = 1'b1;
			e.flags[0] = {1'b0, r.dst} < {1'b0, r.src} + {8'h00, c};
			// Carry compare chains Z across bytes
			e.flags[1] = x == 8'h00 && (r.flags[1] ||
				r.op != cmp_skip_pkg::OP_COMPARE_WITH_CARRY);
			e.flags[2] = x[7];
			// Signed range test, independent of the gate form
			sv = $signed({{2{r.dst[7]}}, r.dst}) -
				$signed({{2{r.src[7]}}, r.src}) - $signed({9'h000, c});
			e.flags[3] = sv > 10'sh07F || sv < 10'sh380;
			e.flags[5] = {1'b0, r.dst[3:0]} < {1'b0, r.src[3:0]} + {4'h0, c};
		end else if (r.op == cmp_skip_pkg::OP_BRANCH_ON_STATUS_FLAG_SET) begin
			e.branched = r.flags[r.flag_sel];
			if (e.branched)
				e.pc_next = r.pc + {{9{r.offset[6]}}, r.offset} + 16'h0001;
		end else begin
			if (r.op == cmp_skip_pkg::OP_COMPARE_SKIP_IF_EQUAL)
				e.skipped = r.dst == r.src;
			else
				e.skipped = (io ? r.io_value[r.bit_sel] : r.src[r.bit_sel]) ^ r.op[0];
			if (e.skipped)
				e.pc_next = r.pc + (r.next_two_words ? 16'h0003 : 16'h0002);
		end
		return e;
	endfunction

	task automatic check(input cmp_skip_pkg::exec_res_type got,
		input cmp_skip_pkg::exec_res_type exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic summarize;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(negedge core_clk) begin
		if (resetn && res_valid === 1'b1) begin
			if (q.size() > 0)
				check(res, q.pop_front());
			else
				check(res, ~res);
		end
	end

	initial begin
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		resetn = 1'b1;
		// Valid stays up in stalls, so refused cycles are exercised too;
		// a refused request is held until the core takes it
		repeat (600) begin
			@(negedge core_clk);
			if (prev_ready === 1'b1) begin
				rnd = {$random(seed), $random(seed), $random(seed)};
				nxt = rnd[$bits(nxt)-1:0];
				nxt.op = cmp_skip_pkg::op_type'(4'({$random(seed)} % 10));
				if (rnd[95])
					nxt.src = nxt.dst;
				req = nxt;
				req_valid = 1'b1;
			end
			prev_ready = req_ready;
			if (req_ready === 1'b1 && req.op != cmp_skip_pkg::OP_NONE)
				q.push_back(model(req));
		end
		while (prev_ready !== 1'b1) begin
			@(negedge core_clk);
			prev_ready = req_ready;
			if (req_ready === 1'b1 && req.op != cmp_skip_pkg::OP_NONE)
				q.push_back(model(req));
		end
		@(negedge core_clk);
		req_valid = 1'b0;
		repeat (5) @(negedge core_clk);
		if (q.size() != 0)
			check(res, ~res);
		summarize();
	end

	initial begin
		#100000;
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end
endmodule
